// [shared/itfr_pkg.sv]
// constants for the input terminal function router
package itfr_pkg;
    localparam int NUM_TERM = 7;
    localparam int CODE_W = 14;
    localparam logic [13:0] CODE_NONE = 14'h270f;
    // function codes
    localparam logic [13:0] FN_LOW = 14'h0000;
    localparam logic [13:0] FN_MID = 14'h0001;
    localparam logic [13:0] FN_HIGH = 14'h0002;
    localparam logic [13:0] FN_SECOND = 14'h0003;
    localparam logic [13:0] FN_ALT_CUR = 14'h0004;
    localparam logic [13:0] FN_JOG = 14'h0005;
    localparam logic [13:0] FN_THERMAL = 14'h0007;
    localparam logic [13:0] FN_EXTRA = 14'h0008;
    localparam logic [13:0] FN_CONV_EN = 14'h000a;
    localparam logic [13:0] FN_INTERLOCK = 14'h000c;
    localparam logic [13:0] FN_PID = 14'h000e;
    localparam logic [13:0] FN_BRAKE = 14'h000f;
    localparam logic [13:0] FN_PANEL_EXT = 14'h0010;
    localparam logic [13:0] FN_CTRL_SW = 14'h0012;
    localparam logic [13:0] FN_OUT_STOP = 14'h0018;
    localparam logic [13:0] FN_SELF_HOLD = 14'h0019;
    localparam logic [13:0] FN_FWD = 14'h003c;
    localparam logic [13:0] FN_REV = 14'h003d;
    localparam logic [13:0] FN_RESET = 14'h003e;
    localparam logic [13:0] FN_PANEL_NET = 14'h0041;
    localparam logic [13:0] FN_EXT_NET = 14'h0042;
    localparam logic [13:0] FN_CMD_SRC = 14'h0043;
    // reset codes per terminal
    localparam logic [13:0] RST_CODE [NUM_TERM] = '{14'h003c, 14'h003d, 14'h0000, 14'h0001,
        14'h0002, 14'h0018, 14'h003e};
    // settings
    localparam logic [1:0] REMOTE_OFF = 2'h0;
    localparam logic [3:0] OPMODE_INTERLOCK = 4'h7;
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int FAST_US = 2000;
    localparam int SLOW_US = 20000;
    localparam int FAST_CYC = FAST_US * (CLK_HZ / 1000000);
    localparam int SLOW_CYC = SLOW_US * (CLK_HZ / 1000000);
    localparam int FILT_SAMPLES = 4;
endpackage

// [shared/itfr_tick_if.sv]
// divider ticks shared between router and divider
`timescale 1ns/1ps
`default_nettype none
interface itfr_tick_if;
    logic fast_tick;
    logic slow_tick;
    modport src (output fast_tick, output slow_tick);
    modport dst (input fast_tick, input slow_tick);
endinterface
`default_nettype wire

// [hw/itfr_tick_div.sv]
// divider producing sampling enables for the terminal filters
`timescale 1ns/1ps
`default_nettype none
module itfr_tick_div #(
    parameter int FAST_DIV = 100,
    parameter int SLOW_DIV = 1000
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    itfr_tick_if.src tick
);
    logic [31:0] fast_cnt_q, fast_cnt_d;
    logic [31:0] slow_cnt_q, slow_cnt_d;

    always_comb begin
        fast_cnt_d = (fast_cnt_q == 32'(FAST_DIV - 1)) ? 32'h0 : fast_cnt_q + 32'h1;
        slow_cnt_d = (slow_cnt_q == 32'(SLOW_DIV - 1)) ? 32'h0 : slow_cnt_q + 32'h1;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fast_cnt_q <= 32'h0;
            slow_cnt_q <= 32'h0;
        end else begin
            fast_cnt_q <= fast_cnt_d;
            slow_cnt_q <= slow_cnt_d;
        end
    end

    assign tick.fast_tick = (fast_cnt_q == 32'(FAST_DIV - 1));
    assign tick.slow_tick = (slow_cnt_q == 32'(SLOW_DIV - 1));
endmodule
`default_nettype wire

// [hw/itfr_router.sv]
// input terminal function router top
`timescale 1ns/1ps
`default_nettype none
module itfr_router #(
    parameter int NUM_TERM = itfr_pkg::NUM_TERM,
    parameter int FAST_CYC = itfr_pkg::FAST_CYC,
    parameter int SLOW_CYC = itfr_pkg::SLOW_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [NUM_TERM-1:0] terminal_in,
    input wire logic code_wr_in,
    input wire logic [2:0] code_idx_in,
    input wire logic [13:0] code_data_in,
    input wire logic [1:0] remote_function_setting_in,
    input wire logic stop_on_contact_setting_in,
    input wire logic [3:0] operation_mode_setting_in,
    input wire logic drive_running_in,
    output logic [NUM_TERM*14-1:0] codes_out,
    output logic low_speed_step_out,
    output logic middle_speed_step_out,
    output logic high_speed_step_out,
    output logic extra_speed_bit_out,
    output logic [3:0] preset_speed_out,
    output logic jog_out,
    output logic [1:0] speed_source_out,
    output logic remote_clear_out,
    output logic remote_decrement_out,
    output logic remote_increment_out,
    output logic [1:0] stop_on_contact_sel_out,
    output logic second_set_select_out,
    output logic alt_current_input_select_out,
    output logic voltage_ref_valid_out,
    output logic external_thermal_trip_out,
    output logic converter_run_enable_out,
    output logic panel_external_interlock_out,
    output logic process_loop_enable_out,
    output logic brake_open_done_out,
    output logic panel_external_switch_out,
    output logic vf_control_out,
    output logic output_stop_input_out,
    output logic start_self_hold_out,
    output logic forward_run_cmd_out,
    output logic reverse_run_cmd_out,
    output logic drive_fault_reset_out,
    output logic panel_network_switch_out,
    output logic external_network_switch_out,
    output logic command_source_switch_out
);
    // ------------------------------------------------------------
    // sampling enables
    // ------------------------------------------------------------
    itfr_tick_if tick ();

    itfr_tick_div #(
        .FAST_DIV(FAST_CYC / itfr_pkg::FILT_SAMPLES),
        .SLOW_DIV(SLOW_CYC / itfr_pkg::FILT_SAMPLES)
    ) u_div (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // code storage
    // ------------------------------------------------------------
    logic [13:0] code_q [NUM_TERM];
    logic [13:0] code_d [NUM_TERM];

    always_comb begin
        for (int i = 0; i < NUM_TERM; i++) begin
            code_d[i] = code_q[i];
        end
        if (code_wr_in && (int'(code_idx_in) < NUM_TERM)) begin
            code_d[code_idx_in] = code_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < NUM_TERM; i++) begin
                code_q[i] <= itfr_pkg::RST_CODE[i];
            end
        end else begin
            for (int i = 0; i < NUM_TERM; i++) begin
                code_q[i] <= code_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // synchronise and filter terminals
    // ------------------------------------------------------------
    logic [NUM_TERM-1:0] sync1_q, sync2_q;
    logic [NUM_TERM-1:0] fast_q, fast_d, slow_q, slow_d;
    logic [NUM_TERM-1:0] fast_hist_q [2], fast_hist_d [2];
    logic [NUM_TERM-1:0] slow_hist_q [2], slow_hist_d [2];

    // two sampled agreements accept a level
    always_comb begin
        fast_hist_d = fast_hist_q;
        slow_hist_d = slow_hist_q;
        fast_d = fast_q;
        slow_d = slow_q;
        if (tick.fast_tick) begin
            fast_hist_d[0] = sync2_q;
            fast_hist_d[1] = fast_hist_q[0];
            for (int i = 0; i < NUM_TERM; i++) begin
                if (fast_hist_q[0][i] == fast_hist_q[1][i]) begin
                    fast_d[i] = fast_hist_q[0][i];
                end
            end
        end
        if (tick.slow_tick) begin
            slow_hist_d[0] = sync2_q;
            slow_hist_d[1] = slow_hist_q[0];
            for (int i = 0; i < NUM_TERM; i++) begin
                if (slow_hist_q[0][i] == slow_hist_q[1][i]) begin
                    slow_d[i] = slow_hist_q[0][i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
            fast_q <= '0;
            slow_q <= '0;
            fast_hist_q <= '{default: '0};
            slow_hist_q <= '{default: '0};
        end else begin
            sync1_q <= terminal_in;
            sync2_q <= sync1_q;
            fast_q <= fast_d;
            slow_q <= slow_d;
            fast_hist_q <= fast_hist_d;
            slow_hist_q <= slow_hist_d;
        end
    end

    // ------------------------------------------------------------
    // function decode
    // ------------------------------------------------------------
    function automatic logic fn_or(input logic [13:0] fn, input logic [NUM_TERM-1:0] lv);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (code_q[i] == fn && code_q[i] != itfr_pkg::CODE_NONE) begin
                r = r | lv[i];
            end
        end
        return r;
    endfunction

    function automatic logic fn_used(input logic [13:0] fn);
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            r = r | (code_q[i] == fn);
        end
        return r;
    endfunction

    logic f_low, f_mid, f_high, f_second, f_ctrl, f_stop, f_conv, f_lock, f_jog, f_extra, f_pid;
    logic f_thermal_open, remote_on, soc_on, vf_q, vf_d;
    logic [3:0] preset;
    logic [1:0] speed_src;

    always_comb begin
        f_low = fn_or(itfr_pkg::FN_LOW, slow_q);
        f_mid = fn_or(itfr_pkg::FN_MID, slow_q);
        f_high = fn_or(itfr_pkg::FN_HIGH, slow_q);
        f_second = fn_or(itfr_pkg::FN_SECOND, slow_q);
        f_ctrl = fn_or(itfr_pkg::FN_CTRL_SW, slow_q);
        f_jog = fn_or(itfr_pkg::FN_JOG, slow_q);
        f_extra = fn_or(itfr_pkg::FN_EXTRA, slow_q);
        f_pid = fn_or(itfr_pkg::FN_PID, slow_q);
        // fast path for stop and run enable
        f_stop = fn_or(itfr_pkg::FN_OUT_STOP, fast_q);
        f_conv = fn_used(itfr_pkg::FN_CONV_EN) ? fn_or(itfr_pkg::FN_CONV_EN, fast_q) : 1'b0;
        f_lock = fn_or(itfr_pkg::FN_INTERLOCK, slow_q);
        f_thermal_open = fn_used(itfr_pkg::FN_THERMAL) & fn_or(itfr_pkg::FN_THERMAL, ~slow_q);
        remote_on = (remote_function_setting_in != itfr_pkg::REMOTE_OFF);
        soc_on = stop_on_contact_setting_in;
        // four bits pick one of fifteen
        preset = {f_extra, f_high, f_mid, f_low};
        if (remote_on) begin
            preset[2:0] = 3'h0;
        end
        if (soc_on) begin
            preset[0] = 1'b0;
        end
        if (f_jog) begin
            speed_src = 2'h3;
        end else if (preset != 4'h0) begin
            speed_src = 2'h2;
        end else if (f_pid) begin
            speed_src = 2'h1;
        end else begin
            speed_src = 2'h0;
        end
        // method only follows switch when stopped
        vf_d = drive_running_in ? vf_q : f_ctrl;
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vf_q <= 1'b0;
        end else begin
            vf_q <= vf_d;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [31:0] out_d, out_q;

    always_comb begin
        out_d = '0;
        out_d[0] = ~remote_on & ~soc_on & f_low;
        out_d[1] = ~remote_on & f_mid;
        out_d[2] = ~remote_on & f_high;
        out_d[3] = remote_on & ~soc_on & f_low;
        out_d[4] = remote_on & f_mid;
        out_d[5] = remote_on & f_high;
        out_d[6] = soc_on & f_low;
        out_d[7] = soc_on & f_second;
        out_d[8] = (~soc_on & f_second) | f_ctrl;
        // alt current input voids voltage ref
        out_d[9] = fn_or(itfr_pkg::FN_ALT_CUR, slow_q);
        out_d[10] = ~out_d[9];
        out_d[11] = f_thermal_open;
        out_d[12] = fn_used(itfr_pkg::FN_CONV_EN) ? f_conv : f_stop;
        // output stop shares interlock in mode 7 when no terminal has interlock
        out_d[13] = (operation_mode_setting_in == itfr_pkg::OPMODE_INTERLOCK &&
                     !fn_used(itfr_pkg::FN_INTERLOCK)) ? f_stop : f_lock;
        out_d[14] = f_pid;
        out_d[15] = fn_or(itfr_pkg::FN_BRAKE, slow_q);
        out_d[16] = fn_or(itfr_pkg::FN_PANEL_EXT, slow_q);
        out_d[17] = vf_q;
        out_d[18] = f_stop;
        out_d[19] = fn_or(itfr_pkg::FN_SELF_HOLD, slow_q);
        out_d[20] = fn_or(itfr_pkg::FN_FWD, slow_q);
        out_d[21] = fn_or(itfr_pkg::FN_REV, slow_q);
        out_d[22] = fn_or(itfr_pkg::FN_RESET, slow_q);
        out_d[23] = fn_or(itfr_pkg::FN_PANEL_NET, slow_q);
        out_d[24] = fn_or(itfr_pkg::FN_EXT_NET, slow_q);
        out_d[25] = fn_or(itfr_pkg::FN_CMD_SRC, slow_q);
        out_d[26] = f_jog;
        out_d[27] = ~remote_on & f_extra;
        out_d[31:28] = speed_src == 2'h2 ? preset : 4'h0;
    end

    logic [1:0] src_q;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_q <= 32'h0000_0400;
            src_q <= 2'h0;
        end else begin
            out_q <= out_d;
            src_q <= speed_src;
        end
    end

    // ------------------------------------------------------------
    // port mapping
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_TERM; g++) begin : g_codes
            assign codes_out[g*14 +: 14] = code_q[g];
        end
    endgenerate

    assign low_speed_step_out = out_q[0];
    assign middle_speed_step_out = out_q[1];
    assign high_speed_step_out = out_q[2];
    assign remote_clear_out = out_q[3];
    assign remote_decrement_out = out_q[4];
    assign remote_increment_out = out_q[5];
    assign stop_on_contact_sel_out = out_q[7:6];
    assign second_set_select_out = out_q[8];
    assign alt_current_input_select_out = out_q[9];
    assign voltage_ref_valid_out = out_q[10];
    assign external_thermal_trip_out = out_q[11];
    assign converter_run_enable_out = out_q[12];
    assign panel_external_interlock_out = out_q[13];
    assign process_loop_enable_out = out_q[14];
    assign brake_open_done_out = out_q[15];
    assign panel_external_switch_out = out_q[16];
    assign vf_control_out = out_q[17];
    assign output_stop_input_out = out_q[18];
    assign start_self_hold_out = out_q[19];
    assign forward_run_cmd_out = out_q[20];
    assign reverse_run_cmd_out = out_q[21];
    assign drive_fault_reset_out = out_q[22];
    assign panel_network_switch_out = out_q[23];
    assign external_network_switch_out = out_q[24];
    assign command_source_switch_out = out_q[25];
    assign jog_out = out_q[26];
    assign extra_speed_bit_out = out_q[27];
    assign preset_speed_out = out_q[31:28];
    assign speed_source_out = src_q;
endmodule
`default_nettype wire

// [test/itfr_chk.sv]
// port assertions for the terminal function router
`timescale 1ns/1ps
`default_nettype none
module itfr_chk #(
    parameter int NUM_TERM = 7
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic code_wr_in,
    input wire logic [2:0] code_idx_in,
    input wire logic [13:0] code_data_in,
    input wire logic [1:0] remote_function_setting_in,
    input wire logic stop_on_contact_setting_in,
    input wire logic drive_running_in,
    input wire logic [NUM_TERM*14-1:0] codes_out,
    input wire logic low_speed_step_out,
    input wire logic middle_speed_step_out,
    input wire logic high_speed_step_out,
    input wire logic [3:0] preset_speed_out,
    input wire logic jog_out,
    input wire logic [1:0] speed_source_out,
    input wire logic remote_clear_out,
    input wire logic remote_decrement_out,
    input wire logic remote_increment_out,
    input wire logic [1:0] stop_on_contact_sel_out,
    input wire logic second_set_select_out,
    input wire logic alt_current_input_select_out,
    input wire logic voltage_ref_valid_out,
    input wire logic vf_control_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // sequences and assertions
    // ----------------------------------------
    sequence s_jog_held;
        jog_out[*3];
    endsequence
    sequence s_code_write;
        code_wr_in && (code_idx_in < 3'h7);
    endsequence
    AST_VREF_INVALID: assert property (
        voltage_ref_valid_out == !alt_current_input_select_out)
        else $error("voltage reference valid is not inverse of alt select");
    AST_REMOTE_STEPS: assert property (
        ($past(remote_function_setting_in) != 2'h0)
        |-> !(low_speed_step_out || middle_speed_step_out || high_speed_step_out))
        else $error("speed step active in remote mode");
    AST_REMOTE_IDLE: assert property (
        ($past(remote_function_setting_in) == 2'h0)
        |-> !(remote_clear_out || remote_decrement_out || remote_increment_out))
        else $error("remote command active with remote off");
    AST_SOC_LOW: assert property (
        $past(stop_on_contact_setting_in) |-> !low_speed_step_out && !remote_clear_out)
        else $error("low step active in stop-on-contact mode");
    AST_SOC_IDLE: assert property (
        !$past(stop_on_contact_setting_in) |-> stop_on_contact_sel_out == 2'h0)
        else $error("stop-on-contact select active with mode off");
    AST_VF_FROZEN: assert property (
        $past(drive_running_in, 2) |-> $stable(vf_control_out))
        else $error("control method changed while running");
    AST_VF_SECOND: assert property (
        $rose(vf_control_out) |-> $past(second_set_select_out))
        else $error("second set not selected with voltage-per-frequency");
    AST_JOG_FIRST: assert property (
        s_jog_held |-> speed_source_out == 2'h3)
        else $error("jog not given top speed priority");
    AST_PRESET_SRC: assert property (
        (speed_source_out != 2'h2)[*2] |-> preset_speed_out == 4'h0)
        else $error("preset speed shown without multi-speed source");
    AST_CODE_WRITE: assert property (
        s_code_write |=> codes_out[14*$past(code_idx_in) +: 14] == $past(code_data_in))
        else $error("terminal code not stored");
endmodule
bind itfr_router itfr_chk #(.NUM_TERM(NUM_TERM)) u_chk (.clk_sys_in, .rstn_in, .code_wr_in,
    .code_idx_in, .code_data_in, .remote_function_setting_in, .stop_on_contact_setting_in,
    .drive_running_in, .codes_out, .low_speed_step_out, .middle_speed_step_out,
    .high_speed_step_out, .preset_speed_out, .jog_out, .speed_source_out, .remote_clear_out,
    .remote_decrement_out, .remote_increment_out, .stop_on_contact_sel_out,
    .second_set_select_out, .alt_current_input_select_out, .voltage_ref_valid_out,
    .vf_control_out);
`default_nettype wire

// [test/itfr_contacts.sv]
// switch and relay contact model on the terminals
`timescale 1ns/1ps
`default_nettype none
module itfr_contacts #(
    parameter int NUM_TERM = 7
) (
    input wire logic [NUM_TERM-1:0] closed_in,
    output logic [NUM_TERM-1:0] terminal_out
);
    // closed contact pulls terminal high
    assign terminal_out = closed_in;
endmodule
`default_nettype wire

// [test/test_input_terminal_function_router.sv]
// self-checking bench for the terminal function router
`timescale 1ns/1ps
`default_nettype none
module test_input_terminal_function_router;
    localparam int FAST = 40;
    localparam int SLOW = 400;
    logic clk_sys_in, rstn_in, code_wr_in, stop_on_contact_setting_in, drive_running_in;
    logic [6:0] closed, terminal_in;
    logic [2:0] code_idx_in;
    logic [13:0] code_data_in;
    logic [1:0] remote_function_setting_in, speed_source_out, stop_on_contact_sel_out;
    logic [3:0] operation_mode_setting_in, preset_speed_out;
    logic [97:0] codes_out;
    logic low_speed_step_out, middle_speed_step_out, high_speed_step_out, extra_speed_bit_out;
    logic jog_out, remote_clear_out, remote_decrement_out, remote_increment_out;
    logic second_set_select_out, alt_current_input_select_out, voltage_ref_valid_out;
    logic external_thermal_trip_out, converter_run_enable_out, panel_external_interlock_out;
    logic process_loop_enable_out, brake_open_done_out, panel_external_switch_out;
    logic vf_control_out, output_stop_input_out, start_self_hold_out, forward_run_cmd_out;
    logic reverse_run_cmd_out, drive_fault_reset_out, panel_network_switch_out;
    logic external_network_switch_out, command_source_switch_out;
    int num_errors, tests_run;
    logic [13:0] tbl [16] = '{itfr_pkg::FN_SECOND, itfr_pkg::FN_ALT_CUR, itfr_pkg::FN_JOG,
        itfr_pkg::FN_THERMAL, itfr_pkg::FN_EXTRA, itfr_pkg::FN_CONV_EN, itfr_pkg::FN_INTERLOCK,
        itfr_pkg::FN_PID, itfr_pkg::FN_BRAKE, itfr_pkg::FN_PANEL_EXT, itfr_pkg::FN_CTRL_SW,
        itfr_pkg::FN_SELF_HOLD, itfr_pkg::FN_RESET, itfr_pkg::FN_PANEL_NET,
        itfr_pkg::FN_EXT_NET, itfr_pkg::FN_CMD_SRC};

    itfr_router #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) DUT (.*);
    itfr_contacts u_contacts (.closed_in(closed), .terminal_out(terminal_in));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask
    task automatic set_code(input logic [2:0] idx, input logic [13:0] code);
        code_idx_in = idx;
        code_data_in = code;
        code_wr_in = 1'b1;
        step(1);
        code_wr_in = 1'b0;
        step(2);
    endtask
    task automatic press(input logic [6:0] lv, input int n);
        closed = lv;
        step(n);
    endtask
    task automatic chk_bit(input logic act, input logic exp, input string what);
        tests_run++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, act, exp);
        end
    endtask
    task automatic chk_word(input logic [97:0] act, input logic [97:0] exp, input string what);
        tests_run++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
        end
    endtask
    function automatic logic fn_out(input logic [13:0] c);
        case (c)
            itfr_pkg::FN_SECOND: return second_set_select_out;
            itfr_pkg::FN_ALT_CUR: return alt_current_input_select_out;
            itfr_pkg::FN_JOG: return jog_out;
            itfr_pkg::FN_THERMAL: return external_thermal_trip_out;
            itfr_pkg::FN_EXTRA: return extra_speed_bit_out;
            itfr_pkg::FN_CONV_EN: return converter_run_enable_out;
            itfr_pkg::FN_INTERLOCK: return panel_external_interlock_out;
            itfr_pkg::FN_PID: return process_loop_enable_out;
            itfr_pkg::FN_BRAKE: return brake_open_done_out;
            itfr_pkg::FN_PANEL_EXT: return panel_external_switch_out;
            itfr_pkg::FN_CTRL_SW: return vf_control_out;
            itfr_pkg::FN_SELF_HOLD: return start_self_hold_out;
            itfr_pkg::FN_RESET: return drive_fault_reset_out;
            itfr_pkg::FN_PANEL_NET: return panel_network_switch_out;
            itfr_pkg::FN_EXT_NET: return external_network_switch_out;
            default: return command_source_switch_out;
        endcase
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        num_errors++;
        print_verdict();
    end
    initial begin
        {rstn_in, code_wr_in, stop_on_contact_setting_in, drive_running_in} = 4'h0;
        {closed, code_idx_in, code_data_in, remote_function_setting_in} = '0;
        operation_mode_setting_in = 4'h0;
        num_errors = 0;
        tests_run = 0;
        step(20);
        chk_word(codes_out, {itfr_pkg::FN_RESET, itfr_pkg::FN_OUT_STOP, itfr_pkg::FN_HIGH,
            itfr_pkg::FN_MID, itfr_pkg::FN_LOW, itfr_pkg::FN_REV, itfr_pkg::FN_FWD}, "codes");
        chk_bit(voltage_ref_valid_out, 1'b1, "vref valid");
        rstn_in = 1'b1;
        step(2);
        press(7'h07, SLOW + 8);
        chk_bit(forward_run_cmd_out, 1'b1, "forward");
        chk_bit(reverse_run_cmd_out, 1'b1, "reverse");
        chk_bit(low_speed_step_out, 1'b1, "low step");
        set_code(6, itfr_pkg::FN_LOW);
        press(7'h40, SLOW + 8);
        chk_bit(low_speed_step_out, 1'b1, "low step or");
        set_code(1, itfr_pkg::FN_JOG);
        set_code(6, itfr_pkg::FN_PID);
        press(7'h46, SLOW + 8);
        chk_bit(speed_source_out == 2'h3, 1'b1, "jog source");
        press(7'h44, SLOW + 8);
        chk_bit(speed_source_out == 2'h2, 1'b1, "multi source");
        chk_bit(preset_speed_out == 4'h1, 1'b1, "preset low");
        press(7'h40, SLOW + 8);
        chk_bit(speed_source_out == 2'h1, 1'b1, "pid source");
        press(7'h1c, SLOW + 8);
        chk_bit(middle_speed_step_out && high_speed_step_out, 1'b1, "mid high steps");
        for (int r = 1; r <= 2; r++) begin
            remote_function_setting_in = 2'(r);
            step(2);
            chk_bit(remote_clear_out && remote_decrement_out, 1'b1, "remote clr dec");
            chk_bit(remote_increment_out, 1'b1, "remote inc");
        end
        remote_function_setting_in = 2'h0;
        set_code(6, itfr_pkg::FN_SECOND);
        stop_on_contact_setting_in = 1'b1;
        press(7'h44, SLOW + 8);
        chk_bit(stop_on_contact_sel_out == 2'h3, 1'b1, "stop select");
        chk_bit(second_set_select_out, 1'b0, "second off");
        stop_on_contact_setting_in = 1'b0;
        set_code(0, itfr_pkg::FN_CONV_EN);
        press(7'h20, FAST + 8);
        chk_bit(output_stop_input_out, 1'b1, "stop fast");
        chk_bit(converter_run_enable_out, 1'b0, "conv assigned");
        chk_bit(panel_external_interlock_out, 1'b0, "lock mode0");
        set_code(0, itfr_pkg::FN_FWD);
        chk_bit(converter_run_enable_out, 1'b1, "conv shared");
        operation_mode_setting_in = 4'h7;
        step(2);
        chk_bit(panel_external_interlock_out, 1'b1, "lock shared");
        press(7'h00, FAST + 8);
        chk_bit(converter_run_enable_out, 1'b0, "conv released");
        foreach (tbl[i]) begin
            set_code(6, tbl[i]);
            press(7'h40, SLOW + 8);
            chk_bit(fn_out(tbl[i]), tbl[i] != itfr_pkg::FN_THERMAL, "fn closed");
            press(7'h00, SLOW + 8);
            chk_bit(fn_out(tbl[i]), tbl[i] == itfr_pkg::FN_THERMAL, "fn open");
        end
        set_code(6, itfr_pkg::CODE_NONE);
        set_code(7, itfr_pkg::FN_JOG);
        chk_word(codes_out, {itfr_pkg::CODE_NONE, itfr_pkg::FN_OUT_STOP, itfr_pkg::FN_HIGH,
            itfr_pkg::FN_MID, itfr_pkg::FN_LOW, itfr_pkg::FN_JOG, itfr_pkg::FN_FWD}, "codes");
        press(7'h40, SLOW + 8);
        chk_bit(command_source_switch_out, 1'b0, "no function");
        chk_bit(external_thermal_trip_out, 1'b0, "thermal unassigned");
        set_code(6, itfr_pkg::FN_CTRL_SW);
        step(SLOW + 8);
        chk_bit(vf_control_out && second_set_select_out, 1'b1, "vf and second");
        drive_running_in = 1'b1;
        press(7'h00, SLOW + 8);
        chk_bit(vf_control_out, 1'b1, "vf held");
        chk_bit(second_set_select_out, 1'b0, "second follows");
        drive_running_in = 1'b0;
        step(2);
        chk_bit(vf_control_out, 1'b0, "vf stopped");
        print_verdict();
    end
endmodule
`default_nettype wire
